// file: logic/rhu_reference.sv
module rhu_reference
    import rhu_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Contact inputs
    input wire logic [TERM_COUNT-1:0] input_terminals,
    input wire logic run_cmd,
    // Function assignment, first terminal in the low byte
    input wire logic [TERM_COUNT*CODE_W-1:0] input_function_select,
    // Setting writes
    input wire logic set_wr,
    input wire logic [1:0] set_sel,
    input wire logic [FREQ_W-1:0] set_data,
    output logic set_refused,
    output logic hold_memory_select,
    // Ramp rates, clock cycles per 0.1 % step
    input wire logic [STEP_W-1:0] accel_step_cycles,
    input wire logic [STEP_W-1:0] decel_step_cycles,
    // Reference sources
    input wire logic [FREQ_W-1:0] analog_reference_input,
    input wire logic multi_step_req,
    input wire logic [FREQ_W-1:0] preset_reference_first,
    // Non-volatile store
    input wire logic [FREQ_W-1:0] nv_stored_value,
    output logic nv_write,
    output logic [FREQ_W-1:0] nv_write_value,
    // Status
    output logic [FREQ_W-1:0] output_frequency,
    output logic [FREQ_W-1:0] reference_monitor,
    output logic freq_agree,
    output logic accelerating,
    output logic decelerating,
    output logic input_config_error,
    output logic multi_step_enabled
);


    function automatic logic [TERM_COUNT-1:0] code_mask(input logic [TERM_COUNT*CODE_W-1:0] sel,
                                                        input logic [CODE_W-1:0] code);
        logic [TERM_COUNT-1:0] m;
        m = '0;
        for (int i = 0; i < TERM_COUNT; i++) begin
            m[i] = (sel[i*CODE_W +: CODE_W] == code);
        end
        return m;
    endfunction

    function automatic logic [FREQ_W-1:0] clamp(input logic [FREQ_W-1:0] v,
                                                 input logic [FREQ_W-1:0] lo,
                                                 input logic [FREQ_W-1:0] hi);
        // Upper limit wins if the limits cross
        if (v > hi) begin
            return hi;
        end else if (v < lo) begin
            return (lo > hi) ? hi : lo;
        end
        return v;
    endfunction

    function automatic logic [FREQ_W-1:0] max2(input logic [FREQ_W-1:0] a, input logic [FREQ_W-1:0] b);
        return (a > b) ? a : b;
    endfunction

    logic [TERM_COUNT-1:0] term_s;
    logic run_s;
    logic run_d_r;
    logic ud_d_r;
    logic hold_d_r;
    logic loaded_r;
    logic hold_mem_r;
    logic [FREQ_W-1:0] upper_r;
    logic [FREQ_W-1:0] lower_r;
    logic [FREQ_W-1:0] master_r;
    logic [FREQ_W-1:0] ref_r;
    logic [FREQ_W-1:0] ref_nxt;
    logic [FREQ_W-1:0] out_r;
    logic [FREQ_W-1:0] out_nxt;
    logic [FREQ_W-1:0] stored_r;
    logic [FREQ_W-1:0] stored_nxt;
    logic store_wr_nxt;
    logic [STEP_W-1:0] step_cnt_r;
    logic accel_r;
    logic decel_r;
    logic cfg_err_r;
    logic refused_r;
    logic nv_write_r;
    rhu_mode_type mode_r;
    rhu_mode_type mode_nxt;

    rhu_sync #(.WIDTH(TERM_COUNT + 1)) u_sync (
        .clk(clk),
        .reset(reset),
        .raw({run_cmd, input_terminals}),
        .level({run_s, term_s})
    );

    // Function decode
    wire [TERM_COUNT-1:0] hold_mask = code_mask(input_function_select, FUNC_RAMP_HOLD);
    wire [TERM_COUNT-1:0] raise_mask = code_mask(input_function_select, FUNC_RAISE);
    wire [TERM_COUNT-1:0] lower_mask = code_mask(input_function_select, FUNC_LOWER);
    wire hold_assigned = |hold_mask;
    wire raise_assigned = |raise_mask;
    wire lower_assigned = |lower_mask;
    wire lone_pair = raise_assigned ^ lower_assigned;
    wire pair_with_hold = (raise_assigned | lower_assigned) & hold_assigned;
    wire cfg_err = lone_pair | pair_with_hold;
    wire updown_mode = raise_assigned & lower_assigned & ~cfg_err;
    wire hold_mode = hold_assigned & ~cfg_err;
    wire hold_mem_eff = hold_mem_r & (hold_mode | updown_mode);

    // Live inputs
    wire hold_on = hold_mode & |(term_s & hold_mask);
    wire raise_on = updown_mode & |(term_s & raise_mask);
    wire lower_on = updown_mode & |(term_s & lower_mask);
    wire raise_only = raise_on & ~lower_on;
    wire lower_only = lower_on & ~raise_on;
    wire ud_on = raise_on | lower_on;
    wire ud_rise = ud_on & ~ud_d_r;
    wire ud_fall = ~ud_on & ud_d_r;
    wire hold_rise = hold_on & ~hold_d_r;
    wire run_rise = run_s & ~run_d_r;

    // Limits
    wire [FREQ_W-1:0] cfg_low = max2(lower_r, master_r);
    wire [FREQ_W-1:0] eff_low = max2(analog_reference_input, cfg_low);
    wire [FREQ_W-1:0] plain_src = (multi_step_req & ~updown_mode) ? preset_reference_first
                                                                    : analog_reference_input;
    wire [FREQ_W-1:0] target = run_s ? ref_r : FREQ_ZERO;
    wire ramp_up = updown_mode ? (raise_only | (out_r < target)) : (out_r < target);
    wire [STEP_W-1:0] step_period = ramp_up ? accel_step_cycles : decel_step_cycles;
    wire step_tick = ({1'b0, step_cnt_r} + 17'h00001) >= {1'b0, step_period};

    // Setting acceptance: only while stopped and in range
    wire set_bad_range = (set_sel == SET_HOLD_MEMORY) ? (set_data > HOLD_MEMORY_MAX) : (set_data > PCT_MAX);
    wire set_ok = set_wr & ~run_s & ~set_bad_range;

    // Frequency reference
    always_comb begin
        ref_nxt = clamp(plain_src, cfg_low, upper_r);
        if (updown_mode) begin
            if (run_rise) begin
                ref_nxt = clamp(hold_mem_eff ? stored_r : FREQ_ZERO, eff_low, upper_r);
            end else if (raise_only & step_tick) begin
                ref_nxt = clamp(ref_r + 11'h001, eff_low, upper_r);
            end else if (lower_only & step_tick & (ref_r != FREQ_ZERO)) begin
                ref_nxt = clamp(ref_r - 11'h001, eff_low, upper_r);
            end else begin
                ref_nxt = clamp(ref_r, eff_low, upper_r);
            end
        end
    end

    // Output frequency
    always_comb begin
        out_nxt = out_r;
        if (run_rise & hold_on) begin
            out_nxt = hold_mem_eff ? stored_r : FREQ_ZERO;
        end else if (hold_on & run_s) begin
            out_nxt = out_r;
        end else if (step_tick & (out_r < target)) begin
            out_nxt = out_r + 11'h001;
        end else if (step_tick & (out_r > target)) begin
            out_nxt = out_r - 11'h001;
        end
    end

    // Retained reference
    always_comb begin
        stored_nxt = stored_r;
        store_wr_nxt = 1'b0;
        if (hold_mem_eff & hold_rise & run_s) begin
            stored_nxt = out_r;
            store_wr_nxt = 1'b1;
        end else if (hold_mem_eff & ud_rise & run_s) begin
            stored_nxt = FREQ_ZERO;
            store_wr_nxt = 1'b1;
        end else if (hold_mem_eff & ud_fall & run_s) begin
            stored_nxt = ref_r;
            store_wr_nxt = 1'b1;
        end
    end

    always_comb begin
        if (!run_s) begin
            mode_nxt = MODE_STOPPED;
        end else if (hold_on) begin
            mode_nxt = MODE_HELD;
        end else begin
            mode_nxt = MODE_RUN;
        end
    end

    // Settings
    always_ff @(posedge clk) begin
        if (reset) begin
            hold_mem_r <= HOLD_MEMORY_RESET;
            upper_r <= UPPER_LIMIT_RESET;
            lower_r <= LOWER_LIMIT_RESET;
            master_r <= MASTER_LOWER_RESET;
            refused_r <= 1'b0;
        end else begin
            refused_r <= set_wr & ~set_ok;
            if (set_ok) begin
                unique case (set_sel)
                    SET_HOLD_MEMORY: hold_mem_r <= set_data[0];
                    SET_UPPER_LIMIT: upper_r <= set_data;
                    SET_LOWER_LIMIT: lower_r <= set_data;
                    SET_MASTER_LOWER: master_r <= set_data;
                endcase
            end
        end
    end

    // Ramp state
    always_ff @(posedge clk) begin
        if (reset) begin
            ref_r <= FREQ_ZERO;
            out_r <= FREQ_ZERO;
            step_cnt_r <= STEP_CNT_RESET;
            mode_r <= MODE_STOPPED;
            accel_r <= 1'b0;
            decel_r <= 1'b0;
        end else begin
            ref_r <= ref_nxt;
            out_r <= out_nxt;
            step_cnt_r <= step_tick ? STEP_CNT_RESET : step_cnt_r + 16'h0001;
            mode_r <= mode_nxt;
            accel_r <= run_s & ~hold_on & (out_nxt < ref_nxt);
            decel_r <= run_s & ~hold_on & (out_nxt > ref_nxt);
        end
    end

    // Store and edge history; the stored value is fetched once after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            stored_r <= FREQ_ZERO;
            loaded_r <= 1'b0;
            nv_write_r <= 1'b0;
            run_d_r <= 1'b0;
            ud_d_r <= 1'b0;
            hold_d_r <= 1'b0;
            cfg_err_r <= 1'b0;
        end else begin
            loaded_r <= 1'b1;
            stored_r <= loaded_r ? stored_nxt : nv_stored_value;
            nv_write_r <= loaded_r & store_wr_nxt;
            run_d_r <= run_s;
            ud_d_r <= ud_on;
            hold_d_r <= hold_on;
            cfg_err_r <= cfg_err;
        end
    end

    assign set_refused = refused_r;
    assign hold_memory_select = hold_mem_r;
    assign nv_write = nv_write_r;
    assign nv_write_value = stored_r;
    assign output_frequency = out_r;
    assign reference_monitor = ref_r;
    assign accelerating = accel_r;
    assign decelerating = decel_r;
    assign input_config_error = cfg_err_r;
    assign multi_step_enabled = ~updown_mode;
    assign freq_agree = (mode_r != MODE_STOPPED) & ~accel_r & ~decel_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    hold_freeze_a: assert property ((hold_on && run_s && !run_rise) |=> $stable(out_r))
        else $error("output moved during ramp hold");
    run_zero_a: assert property ((run_rise && hold_on && !hold_mem_eff) |=> out_r == FREQ_ZERO)
        else $error("output not zero on run under hold");
    lone_error_a: assert property (lone_pair |=> input_config_error)
        else $error("lone raise or lower not flagged");
    pair_hold_error_a: assert property (pair_with_hold |=> input_config_error)
        else $error("pair with ramp hold not flagged");
    upper_clamp_a: assert property (updown_mode |-> ref_nxt <= upper_r)
        else $error("reference above upper limit");
    lower_clamp_a: assert property ((updown_mode && eff_low <= upper_r) |-> ref_nxt >= eff_low)
        else $error("reference below effective lower limit");
    setting_lock_a: assert property ((set_wr && run_s) |=> set_refused && $stable(hold_mem_r))
        else $error("setting accepted while running");
    step_rate_a: assert property (!(run_rise && hold_on) |=>
                                  (out_r <= $past(out_r) + 11'h001) && ($past(out_r) <= out_r + 11'h001))
        else $error("output stepped faster than ramp");
    clear_store_a: assert property ((loaded_r && hold_mem_eff && ud_rise && run_s && !hold_rise) |=>
                                    stored_r == FREQ_ZERO && nv_write)
        else $error("store not cleared on raise or lower");
    agree_run_a: assert property (freq_agree |-> $past(run_s))
        else $error("agreement without run");

    hold_run_c: cover property (run_s && hold_on ##1 run_s && !hold_on);
    raise_c: cover property (raise_only && run_s ##1 ref_r > eff_low);
    cfg_err_c: cover property (input_config_error);
    agree_c: cover property (run_s ##1 freq_agree);

endmodule

// file: inc/rhu_pkg.sv
package rhu_pkg;

    localparam int TERM_COUNT = 10;
    localparam int CODE_W = 8;
    localparam int FREQ_W = 11;
    localparam int STEP_W = 16;

    // Contact input function codes
    localparam logic [CODE_W-1:0] FUNC_RAMP_HOLD = 8'h0A;
    localparam logic [CODE_W-1:0] FUNC_RAISE = 8'h10;
    localparam logic [CODE_W-1:0] FUNC_LOWER = 8'h11;

    // Percentages of maximum output frequency, in 0.1 % units, except the hold memory limit and reset, which are on/off flags
    localparam logic [FREQ_W-1:0] PCT_MAX = 11'h44C;
    localparam logic [FREQ_W-1:0] UPPER_LIMIT_RESET = 11'h3E8;
    localparam logic [FREQ_W-1:0] LOWER_LIMIT_RESET = 11'h000;
    localparam logic [FREQ_W-1:0] MASTER_LOWER_RESET = 11'h000;
    localparam logic [FREQ_W-1:0] FREQ_ZERO = 11'h000;
    localparam logic [FREQ_W-1:0] HOLD_MEMORY_MAX = 11'h001;
    localparam logic HOLD_MEMORY_RESET = 1'b0;

    // Setting selectors
    localparam logic [1:0] SET_HOLD_MEMORY = 2'h0;
    localparam logic [1:0] SET_UPPER_LIMIT = 2'h1;
    localparam logic [1:0] SET_LOWER_LIMIT = 2'h2;
    localparam logic [1:0] SET_MASTER_LOWER = 2'h3;

    localparam logic [STEP_W-1:0] STEP_CNT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        MODE_STOPPED,
        MODE_RUN,
        MODE_HELD
    } rhu_mode_type;

endpackage

// file: logic/rhu_sync.sv
module rhu_sync
    import rhu_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Raw and filtered levels
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] level_nxt;

    // A bit changes only once the two later stages agree; a disagreement keeps the old level
    assign level_nxt = (s2_r & s3_r) | (level_r & (s2_r | s3_r));
    assign level = level_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

endmodule

// file: sim/rhu_contact_model.sv
module rhu_contact_model
    import rhu_pkg::*;
(
    // Clock
    input wire logic clk,
    // Sequencer requests
    input wire logic [TERM_COUNT-1:0] want_terms,
    input wire logic want_run,
    // Contact levels
    output logic [TERM_COUNT-1:0] input_terminals,
    output logic run_cmd
);
    timeunit 1ns;
    timeprecision 1ns;

    // Contacts move away from the sampling edge, so the filter never sees a half step
    always @(negedge clk) begin
        input_terminals <= want_terms;
        // Run comes from its own request, want_run, also while a hold is already closed
        run_cmd <= want_run;
    end
endmodule

// file: sim/test_ramp_hold_up_down_reference.sv
module test_ramp_hold_up_down_reference
    import rhu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, reset, run_want, set_wr, set_refused, hold_memory_select, nv_write, freq_agree;
    logic accelerating, decelerating, input_config_error, multi_step_enabled, run_cmd, refused, multi_req;
    logic [TERM_COUNT-1:0] terms_want, input_terminals;
    logic [TERM_COUNT*CODE_W-1:0] fsel;
    logic [1:0] set_sel;
    logic [FREQ_W-1:0] set_data, analog, nv_stored, nv_write_value, output_frequency, reference_monitor;
    logic [FREQ_W-1:0] nv_seen, held;
    int fails, checks_done, cycles;

    rhu_contact_model rhu_contact_model_inst (.clk(clk), .want_terms(terms_want), .want_run(run_want),
        .input_terminals(input_terminals), .run_cmd(run_cmd));

    rhu_reference rhu_reference_inst (.clk(clk), .reset(reset), .input_terminals(input_terminals),
        .run_cmd(run_cmd), .input_function_select(fsel), .set_wr(set_wr), .set_sel(set_sel),
        .set_data(set_data), .set_refused(set_refused), .hold_memory_select(hold_memory_select),
        .accel_step_cycles(16'h0002), .decel_step_cycles(16'h0002), .analog_reference_input(analog),
        .multi_step_req(multi_req), .preset_reference_first(11'h3E8), .nv_stored_value(nv_stored),
        .nv_write(nv_write), .nv_write_value(nv_write_value), .output_frequency(output_frequency),
        .reference_monitor(reference_monitor), .freq_agree(freq_agree), .accelerating(accelerating),
        .decelerating(decelerating), .input_config_error(input_config_error),
        .multi_step_enabled(multi_step_enabled));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Remember the last value sent to the retention store; sampled mid-cycle, away from the launch edge
    always @(negedge clk) begin
        if (nv_write === 1'b1) begin
            nv_seen <= nv_write_value;
        end
    end

    // Whole sequence needs about 670 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [FREQ_W-1:0] seen, input logic [FREQ_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Refusal pulse lands on the first edge after the write; the second edge is sampled too
    task automatic put(input logic [1:0] sel, input logic [FREQ_W-1:0] d);
        set_sel = sel;
        set_data = d;
        set_wr = 1'b1;
        @(posedge clk) #1 refused = set_refused;
        @(negedge clk) set_wr = 1'b0;
        @(posedge clk) #1 refused = refused | set_refused;
        cyc(1);
    endtask

    task automatic stop_test;
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset;
        reset = 1'b1;
        cyc(5);
        reset = 1'b0;
        cyc(2);
    endtask

    initial begin
        {run_want, set_wr, set_sel, set_data, terms_want, fsel, analog, nv_stored, multi_req} = '0;
        nv_seen = 11'h7FF;
        do_reset();
        check("hold_mem", hold_memory_select, 1'b0);
        check("multi_step", multi_step_enabled, 1'b1);
        fsel[7:0] = FUNC_RAISE;
        cyc(3);
        check("cfg_err", input_config_error, 1'b1);
        fsel[15:8] = FUNC_LOWER;
        cyc(3);
        check("cfg_err", input_config_error, 1'b0);
        check("multi_step", multi_step_enabled, 1'b0);
        fsel[23:16] = FUNC_RAMP_HOLD;
        cyc(3);
        check("cfg_err", input_config_error, 1'b1);
        fsel[23:16] = 8'h00;
        put(SET_HOLD_MEMORY, 11'h002);
        check("refused", refused, 1'b1);
        put(SET_UPPER_LIMIT, 11'h44D);
        check("refused", refused, 1'b1);
        put(SET_UPPER_LIMIT, 11'h032);
        check("refused", refused, 1'b0);
        put(SET_LOWER_LIMIT, 11'h01E);
        put(SET_HOLD_MEMORY, 11'h001);
        check("hold_mem", hold_memory_select, 1'b1);
        analog = 11'h014;
        run_want = 1'b1;
        cyc(12);
        check("ramping", output_frequency < 11'h01E, 1'b1);
        check("accel", accelerating, 1'b1);
        cyc(80);
        check("out", output_frequency, 11'h01E);
        check("agree", freq_agree, 1'b1);
        terms_want[0] = 1'b1;
        cyc(8);
        check("nv", nv_seen, FREQ_ZERO);
        cyc(60);
        check("ref", reference_monitor, 11'h032);
        terms_want[0] = 1'b0;
        cyc(8);
        check("nv", nv_seen, 11'h032);
        terms_want[1:0] = 2'b11;
        cyc(30);
        check("ref", reference_monitor, 11'h032);
        check("out", output_frequency, 11'h032);
        terms_want[1:0] = 2'b10;
        cyc(20);
        check("decel", decelerating, 1'b1);
        cyc(60);
        check("ref", reference_monitor, 11'h01E);
        analog = 11'h028;
        multi_req = 1'b1;
        cyc(10);
        check("ref", reference_monitor, 11'h028);
        terms_want = '0;
        put(SET_HOLD_MEMORY, 11'h000);
        check("refused", refused, 1'b1);
        run_want = 1'b0;
        cyc(120);
        check("out", output_frequency, FREQ_ZERO);
        multi_req = 1'b0;
        fsel = {56'h0, FUNC_RAMP_HOLD, 16'h0000};
        run_want = 1'b1;
        cyc(30);
        terms_want[2] = 1'b1;
        cyc(8);
        held = output_frequency;
        cyc(20);
        check("held", output_frequency, held);
        check("accel", accelerating, 1'b0);
        check("nv", nv_seen, held);
        terms_want[2] = 1'b0;
        cyc(100);
        check("out", output_frequency, 11'h028);
        multi_req = 1'b1;
        cyc(2);
        check("ref", reference_monitor, 11'h032);
        multi_req = 1'b0;
        run_want = 1'b0;
        // Stop only briefly so the output is still well above zero when run returns
        cyc(8);
        put(SET_HOLD_MEMORY, 11'h000);
        terms_want[2] = 1'b1;
        cyc(8);
        run_want = 1'b1;
        cyc(20);
        check("out", output_frequency, FREQ_ZERO);
        run_want = 1'b0;
        terms_want = '0;
        nv_stored = 11'h0C8;
        cyc(10);
        do_reset();
        check("hold_mem", hold_memory_select, 1'b0);
        put(SET_HOLD_MEMORY, 11'h001);
        terms_want[2] = 1'b1;
        cyc(8);
        run_want = 1'b1;
        cyc(8);
        check("out", output_frequency, 11'h0C8);
        stop_test();
    end
endmodule
